// *** rtl/dwf_pkg.sv ***
// constants, frame layout and register defaults for the write frame decoder
// assumes a 12-bit quad-channel converter core fed from these registers
package dwf_pkg;

  // ---------------------------------------------------------------
  // frame geometry
  // ---------------------------------------------------------------
  localparam int unsigned FRAME_BITS     = 24;
  localparam int unsigned FRAME_CHK_BITS = 32;
  localparam int unsigned CHANNELS       = 4;
  localparam int unsigned CODE_W         = 12;
  localparam int unsigned CTRL_DATA_W    = 13;
  localparam logic [5:0]  LEN_PLAIN      = 6'h18;
  localparam logic [5:0]  LEN_CHECKED    = 6'h20;
  localparam logic [5:0]  LEN_MAX        = 6'h3f;

  // ---------------------------------------------------------------
  // field positions inside the 24-bit frame
  // ---------------------------------------------------------------
  localparam int unsigned POS_RW       = 23;
  localparam int unsigned POS_CODE_MSB = 15;
  localparam int unsigned POS_CODE_LSB = 4;
  localparam int unsigned POS_CSEL_MSB = 15;
  localparam int unsigned POS_CSEL_LSB = 13;
  localparam int unsigned POS_CDAT_MSB = 12;

  // ---------------------------------------------------------------
  // destination select codes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    DWF_DEST_DATA      = 3'h0,
    DWF_DEST_RESERVED  = 3'h1,
    DWF_DEST_GAIN_ONE  = 3'h2,
    DWF_DEST_GAIN_ALL  = 3'h3,
    DWF_DEST_OFFS_ONE  = 3'h4,
    DWF_DEST_OFFS_ALL  = 3'h5,
    DWF_DEST_CLEAR_ONE = 3'h6,
    DWF_DEST_CONTROL   = 3'h7
  } dwf_dest_e;

  // ---------------------------------------------------------------
  // frame header as it arrives, msb first
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        read_not_write;
    logic [1:0]  device_addr;
    logic [2:0]  dest_select_field;
    logic [1:0]  channel_select;
    logic [15:0] payload;
  } dwf_frame_s;

  // control register write as handed on
  typedef struct packed {
    logic [2:0]             control_select_field;
    logic [1:0]             channel_select;
    logic [CTRL_DATA_W-1:0] data;
  } dwf_ctrl_s;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [11:0] RST_DATA   = 12'h000;
  localparam logic [11:0] RST_GAIN   = 12'hfff;
  localparam logic [11:0] RST_OFFSET = 12'h800;
  localparam logic [11:0] RST_CLEAR  = 12'h000;

endpackage : dwf_pkg

// *** rtl/dwf_pin_sync.sv ***
// three-stage pin synchroniser with agreement filter
// assumes asynchronous pins; output follows once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module dwf_pin_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         reset_n,
  // pins in, clean levels out
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out
);

  logic [W-1:0] st1_reg;
  logic [W-1:0] st2_reg;
  logic [W-1:0] st3_reg;
  logic [W-1:0] out_reg;
  logic [W-1:0] out_next;

  // ---------------------------------------------------------------
  // agreement filter
  // ---------------------------------------------------------------
  // stage one feeds stage two only
  always_comb begin
    out_next = out_reg;
    for (int i = 0; i < int'(W); i++) begin
      if (st2_reg[i] == st3_reg[i]) begin
        out_next[i] = st3_reg[i];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st1_reg <= '0;
      st2_reg <= '0;
      st3_reg <= '0;
      out_reg <= '0;
    end else begin
      st1_reg <= pin_in;
      st2_reg <= st1_reg;
      st3_reg <= st2_reg;
      out_reg <= out_next;
    end
  end

  assign level_out = out_reg;

endmodule : dwf_pin_sync
`default_nettype wire

// *** rtl/dwf_frame_decoder.sv ***
// serial write frame decoder for a quad-channel 12-bit converter
// assumes serial pins are asynchronous to ref_clk, data sampled on serial clock fall,
// and serial clock no faster than ref_clk / 8 for clean edge detection
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - three-bit destination field picks the register a frame writes, in one channel or in all four
// - destination all ones is a control write steered by the control select field
// - code 000 writes one channel output code; code 001 is reserved
// - code 010 writes gain of the selected channel only
// - code 011 writes one gain value into all four channels
// - code 100 writes offset of the selected channel only
// - code 101 writes one offset value into all four channels
// - code 110 writes clear value of the selected channel
// - channel field 00 to 11 selects channel A to D
// - broadcast writes ignore the channel field; control writes pass it on raw in ctrl_write
// - output data sits in D15 to D4, D3 to D0 ignored
// - frames are 24 bits, or 32 with eight check bits when enabled
// - top bit zero writes, one requests a read of the register
// - device address field must match the two strap pins
module dwf_frame_decoder
  import dwf_pkg::*;
(
  // clock and reset
  input  wire logic                                  ref_clk,
  input  wire logic                                  reset_n,
  // serial pins
  input  wire logic                                  serial_clk,
  input  wire logic                                  frame_sync_n,
  input  wire logic                                  serial_din,
  // configuration pins
  input  wire logic                                  packet_error_check,
  input  wire logic                                  addr_strap_pin_hi,
  input  wire logic                                  addr_strap_pin_lo,
  // per-channel registers
  output logic [dwf_pkg::CHANNELS-1:0][dwf_pkg::CODE_W-1:0] channel_output_code,
  output logic [dwf_pkg::CHANNELS-1:0][dwf_pkg::CODE_W-1:0] gain_code,
  output logic [dwf_pkg::CHANNELS-1:0][dwf_pkg::CODE_W-1:0] offset_code,
  output logic [dwf_pkg::CHANNELS-1:0][dwf_pkg::CODE_W-1:0] clear_code,
  // control writes and read requests
  output logic                                       ctrl_write_pulse,
  output dwf_pkg::dwf_ctrl_s                         ctrl_write,
  output logic                                       read_req_pulse,
  output logic [2:0]                                 read_dest,
  output logic [1:0]                                 read_channel,
  // frame status
  output logic                                       frame_discard_pulse
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [5:0] pins_s;

  dwf_pin_sync #(
    .W (6)
  ) u_sync (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .pin_in    ({serial_clk, frame_sync_n, serial_din, packet_error_check,
                 addr_strap_pin_hi, addr_strap_pin_lo}),
    .level_out (pins_s)
  );

  logic       sclk_s;
  logic       sync_n_s;
  logic       din_s;
  logic       check_s;
  logic [1:0] strap_s;

  assign sclk_s   = pins_s[5];
  assign sync_n_s = pins_s[4];
  assign din_s    = pins_s[3];
  assign check_s  = pins_s[2];
  assign strap_s  = pins_s[1:0];

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // single-channel code hits the named channel, broadcast code hits all
  function automatic logic chan_hit(input logic [2:0] dest, input logic [2:0] one_code,
                                    input logic [2:0] all_code, input logic [1:0] chan,
                                    input int idx);
    logic hit;
    hit = 1'b0;
    if (dest == all_code) begin
      hit = 1'b1;
    end else if ((dest == one_code) && (chan == idx[1:0])) begin
      hit = 1'b1;
    end
    return hit;
  endfunction : chan_hit

  // ---------------------------------------------------------------
  // frame state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_APPLY = 2'b11
  } dwf_state_e;

  dwf_state_e  state_reg;
  dwf_state_e  state_next;
  logic        sclk_prev_reg;
  logic        sclk_prev_next;
  logic        sync_prev_reg;
  logic        sync_prev_next;
  logic [5:0]  cnt_reg;
  logic [5:0]  cnt_next;
  logic [31:0] shift_reg;
  logic [31:0] shift_next;
  logic        check_reg;
  logic        check_next;

  always_comb begin
    state_next     = state_reg;
    sclk_prev_next = sclk_s;
    sync_prev_next = sync_n_s;
    cnt_next       = cnt_reg;
    shift_next     = shift_reg;
    check_next     = check_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (sync_prev_reg && !sync_n_s) begin
          state_next = ST_SHIFT;
          cnt_next   = 6'h00;
          check_next = check_s;
        end
      end
      ST_SHIFT: begin
        if (sync_n_s) begin
          state_next = ST_APPLY;
        end else if (sclk_prev_reg && !sclk_s) begin
          shift_next = {shift_reg[30:0], din_s};
          if (cnt_reg != LEN_MAX) begin
            cnt_next = cnt_reg + 6'h01;
          end
        end
      end
      ST_APPLY: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg     <= ST_IDLE;
      sclk_prev_reg <= 1'b0;
      // synchronised pin reads low after reset; a high here fakes a frame start
      sync_prev_reg <= 1'b0;
      cnt_reg       <= 6'h00;
      shift_reg     <= 32'h0000_0000;
      check_reg     <= 1'b0;
    end else begin
      state_reg     <= state_next;
      sclk_prev_reg <= sclk_prev_next;
      sync_prev_reg <= sync_prev_next;
      cnt_reg       <= cnt_next;
      shift_reg     <= shift_next;
      check_reg     <= check_next;
    end
  end

  // ---------------------------------------------------------------
  // frame decode
  // ---------------------------------------------------------------
  dwf_frame_s frame;
  logic       len_ok;
  logic       addr_ok;
  logic       accept;

  // check byte is stripped, not verified here
  assign frame   = check_reg ? shift_reg[31:8] : shift_reg[23:0];
  assign len_ok  = (cnt_reg == (check_reg ? LEN_CHECKED : LEN_PLAIN));
  assign addr_ok = (frame.device_addr == strap_s);
  assign accept  = (state_reg == ST_APPLY) && len_ok && addr_ok
                   && (frame.dest_select_field != DWF_DEST_RESERVED);

  // ---------------------------------------------------------------
  // register file and strobes
  // ---------------------------------------------------------------
  logic [CHANNELS-1:0][CODE_W-1:0] data_reg, data_next;
  logic [CHANNELS-1:0][CODE_W-1:0] gain_reg, gain_next;
  logic [CHANNELS-1:0][CODE_W-1:0] offs_reg, offs_next;
  logic [CHANNELS-1:0][CODE_W-1:0] clr_reg, clr_next;
  logic                            ctrl_pulse_reg, ctrl_pulse_next;
  dwf_ctrl_s                       ctrl_reg, ctrl_next;
  logic                            rd_pulse_reg, rd_pulse_next;
  logic [2:0]                      rd_dest_reg, rd_dest_next;
  logic [1:0]                      rd_chan_reg, rd_chan_next;
  logic                            disc_reg, disc_next;
  logic [CODE_W-1:0]               code;
  logic [2:0]                      dest;

  assign code = frame.payload[POS_CODE_MSB:POS_CODE_LSB];
  assign dest = frame.dest_select_field;

  always_comb begin
    data_next       = data_reg;
    gain_next       = gain_reg;
    offs_next       = offs_reg;
    clr_next        = clr_reg;
    ctrl_pulse_next = 1'b0;
    ctrl_next       = ctrl_reg;
    rd_pulse_next   = 1'b0;
    rd_dest_next    = rd_dest_reg;
    rd_chan_next    = rd_chan_reg;
    disc_next       = (state_reg == ST_APPLY) && !accept;
    if (accept && frame.read_not_write) begin
      // read path lives elsewhere; only the request is raised
      rd_pulse_next = 1'b1;
      rd_dest_next  = dest;
      rd_chan_next  = frame.channel_select;
    end else if (accept) begin
      for (int i = 0; i < int'(CHANNELS); i++) begin
        if ((dest == DWF_DEST_DATA) && (frame.channel_select == i[1:0])) begin
          data_next[i] = code;
        end
        if (chan_hit(dest, DWF_DEST_GAIN_ONE, DWF_DEST_GAIN_ALL, frame.channel_select, i)) begin
          gain_next[i] = code;
        end
        if (chan_hit(dest, DWF_DEST_OFFS_ONE, DWF_DEST_OFFS_ALL, frame.channel_select, i)) begin
          offs_next[i] = code;
        end
        if ((dest == DWF_DEST_CLEAR_ONE) && (frame.channel_select == i[1:0])) begin
          clr_next[i] = code;
        end
      end
      if (dest == DWF_DEST_CONTROL) begin
        ctrl_pulse_next                = 1'b1;
        ctrl_next.control_select_field = frame.payload[POS_CSEL_MSB:POS_CSEL_LSB];
        // passed on raw; per-channel control registers use it, global ones must not
        ctrl_next.channel_select       = frame.channel_select;
        ctrl_next.data                 = frame.payload[POS_CDAT_MSB:0];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      data_reg       <= {CHANNELS{RST_DATA}};
      gain_reg       <= {CHANNELS{RST_GAIN}};
      offs_reg       <= {CHANNELS{RST_OFFSET}};
      clr_reg        <= {CHANNELS{RST_CLEAR}};
      ctrl_pulse_reg <= 1'b0;
      ctrl_reg       <= '0;
      rd_pulse_reg   <= 1'b0;
      rd_dest_reg    <= 3'h0;
      rd_chan_reg    <= 2'h0;
      disc_reg       <= 1'b0;
    end else begin
      data_reg       <= data_next;
      gain_reg       <= gain_next;
      offs_reg       <= offs_next;
      clr_reg        <= clr_next;
      ctrl_pulse_reg <= ctrl_pulse_next;
      ctrl_reg       <= ctrl_next;
      rd_pulse_reg   <= rd_pulse_next;
      rd_dest_reg    <= rd_dest_next;
      rd_chan_reg    <= rd_chan_next;
      disc_reg       <= disc_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign channel_output_code = data_reg;
  assign gain_code           = gain_reg;
  assign offset_code         = offs_reg;
  assign clear_code          = clr_reg;
  assign ctrl_write_pulse    = ctrl_pulse_reg;
  assign ctrl_write          = ctrl_reg;
  assign read_req_pulse      = rd_pulse_reg;
  assign read_dest           = rd_dest_reg;
  assign read_channel        = rd_chan_reg;
  assign frame_discard_pulse = disc_reg;

endmodule : dwf_frame_decoder
`default_nettype wire

// *** tb/dwf_host_model.sv ***
// serial host that shifts write frames into the decoder pins
// assumes ref_clk free running; caller composes frame bits and length
`timescale 1ns/1ps
`default_nettype none
module dwf_host_model (
  // clock
  input  wire logic ref_clk,
  // serial pins
  output var  logic serial_clk,
  output var  logic frame_sync_n,
  output var  logic serial_din
);
  // ------------------------------------------------------------
  // frame shifter
  // ------------------------------------------------------------
  // clock idles high and stands still between frames
  initial begin
    serial_clk   = 1'b1;
    frame_sync_n = 1'b1;
    serial_din   = 1'b0;
  end

  task automatic tick(input int k);
    repeat (k) @(negedge ref_clk);
  endtask : tick

  // phases of five cycles keep above the four-cycle minimum
  task automatic send(input logic [31:0] f, input int n);
    frame_sync_n = 1'b0;
    tick(5);
    for (int i = n - 1; i >= 0; i--) begin
      serial_din = f[i];
      tick(5);
      serial_clk = 1'b0;
      tick(5);
      serial_clk = 1'b1;
    end
    tick(5);
    frame_sync_n = 1'b1;
    // released line shows no stale value
    serial_din = ~serial_din;
    tick(8);
  endtask : send
endmodule : dwf_host_model
`default_nettype wire

// *** tb/dwf_frame_decoder_props.sv ***
// concurrent checks on the write frame decoder ports
// assumes frame_sync_n stays high at least eight cycles after a frame
`timescale 1ns/1ps
`default_nettype none
module dwf_frame_decoder_props
  import dwf_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // frame pin
  input wire logic frame_sync_n,
  // registers
  input wire logic [dwf_pkg::CHANNELS-1:0][dwf_pkg::CODE_W-1:0] channel_output_code,
  input wire logic [dwf_pkg::CHANNELS-1:0][dwf_pkg::CODE_W-1:0] gain_code,
  input wire logic [dwf_pkg::CHANNELS-1:0][dwf_pkg::CODE_W-1:0] offset_code,
  input wire logic [dwf_pkg::CHANNELS-1:0][dwf_pkg::CODE_W-1:0] clear_code,
  // events
  input wire logic               ctrl_write_pulse,
  input wire dwf_pkg::dwf_ctrl_s ctrl_write,
  input wire logic               read_req_pulse,
  input wire logic [2:0]         read_dest,
  input wire logic [1:0]         read_channel,
  input wire logic               frame_discard_pulse
);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence ctl_once;
    ctrl_write_pulse ##1 !ctrl_write_pulse;
  endsequence
  sequence frame_closed;
    frame_sync_n && $past(frame_sync_n, 3);
  endsequence
  sequence codes_still;
    $stable(channel_output_code) && $stable(gain_code) && $stable(offset_code)
      && $stable(clear_code);
  endsequence

  pulse_alone_a: assert property ($onehot0({ctrl_write_pulse, read_req_pulse,
    frame_discard_pulse})) else $error("two frame outcomes at once");
  ctl_width_a: assert property (ctrl_write_pulse |-> ctl_once)
    else $error("control pulse too long");
  ctl_hold_a: assert property ($changed(ctrl_write) |-> ctrl_write_pulse)
    else $error("control word moved without pulse");
  read_hold_a: assert property ($changed({read_dest, read_channel}) |-> read_req_pulse)
    else $error("read fields moved without pulse");
  discard_quiet_a: assert property (frame_discard_pulse |-> codes_still
    ##0 $stable(ctrl_write)) else $error("discarded frame changed state");
  read_quiet_a: assert property (read_req_pulse |-> codes_still)
    else $error("read frame changed a register");
  ctl_quiet_a: assert property (ctrl_write_pulse |-> codes_still)
    else $error("control write changed a register");
  one_class_a: assert property ($changed(gain_code) |-> $stable(offset_code)
    && $stable(clear_code) && $stable(channel_output_code))
    else $error("gain write touched another class");
  after_frame_a: assert property ((!$stable(channel_output_code) || frame_discard_pulse
    || read_req_pulse) |-> frame_closed) else $error("outcome before frame end");
  data_single_a: assert property ($changed(channel_output_code) |-> $onehot({
    channel_output_code[3] != $past(channel_output_code[3]),
    channel_output_code[2] != $past(channel_output_code[2]),
    channel_output_code[1] != $past(channel_output_code[1]),
    channel_output_code[0] != $past(channel_output_code[0])}))
    else $error("data write reached several channels");
endmodule : dwf_frame_decoder_props

bind dwf_frame_decoder dwf_frame_decoder_props chk (.ref_clk, .reset_n, .frame_sync_n,
  .channel_output_code, .gain_code, .offset_code, .clear_code, .ctrl_write_pulse,
  .ctrl_write, .read_req_pulse, .read_dest, .read_channel, .frame_discard_pulse);
`default_nettype wire

// *** tb/dwf_frame_decoder_bench.sv ***
// self-checking bench for the write frame decoder
// assumes host model drives the serial pins; straps held at 10
`timescale 1ns/1ps
`default_nettype none
module dwf_frame_decoder_bench;
  import dwf_pkg::*;
  // ------------------------------------------------------------
  // signals and expectations
  // ------------------------------------------------------------
  localparam logic [1:0] A = 2'h2;
  logic ref_clk, reset_n, packet_error_check, addr_strap_pin_hi, addr_strap_pin_lo;
  logic serial_clk, frame_sync_n, serial_din;
  logic [CHANNELS-1:0][CODE_W-1:0] channel_output_code, gain_code, offset_code, clear_code;
  logic [CHANNELS-1:0][CODE_W-1:0] e_out, e_gain, e_offs, e_clr;
  logic ctrl_write_pulse, read_req_pulse, frame_discard_pulse;
  dwf_ctrl_s ctrl_write, e_ctl;
  logic [2:0] read_dest;
  logic [1:0] read_channel;
  logic [4:0] e_rd;
  logic [15:0] n_ctl, n_rd, n_dis, x_ctl, x_rd, x_dis;
  int errors, total_checks;
  logic [23:0] tbl [10] = '{ {1'b0, A, 3'h2, 2'h2, 16'h5a3f}, {1'b0, A, 3'h3, 2'h1, 16'h7e10},
    {1'b0, A, 3'h2, 2'h0, 16'h1235}, {1'b0, A, 3'h4, 2'h3, 16'h0c4f},
    {1'b0, A, 3'h5, 2'h2, 16'h9d20}, {1'b0, A, 3'h6, 2'h1, 16'h4b6a},
    {1'b0, A, 3'h7, 2'h3, 16'h3abc}, {1'b1, A, 3'h4, 2'h1, 16'h0000},
    {1'b0, A, 3'h1, 2'h0, 16'hffff}, {1'b0, 2'h1, 3'h0, 2'h0, 16'h8880} };

  dwf_frame_decoder uut (.ref_clk, .reset_n, .serial_clk, .frame_sync_n, .serial_din,
    .packet_error_check, .addr_strap_pin_hi, .addr_strap_pin_lo, .channel_output_code,
    .gain_code, .offset_code, .clear_code, .ctrl_write_pulse, .ctrl_write,
    .read_req_pulse, .read_dest, .read_channel, .frame_discard_pulse);
  dwf_host_model host (.ref_clk, .serial_clk, .frame_sync_n, .serial_din);

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (ctrl_write_pulse === 1'b1) n_ctl <= n_ctl + 16'h1;
    if (read_req_pulse === 1'b1) n_rd <= n_rd + 16'h1;
    if (frame_discard_pulse === 1'b1) n_dis <= n_dis + 16'h1;
  end

  task automatic stop_test();
    if (errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test

  task automatic cmp(input string nm, input logic [47:0] e, input logic [47:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  task automatic check_all();
    cmp("output", e_out, channel_output_code);
    cmp("gain", e_gain, gain_code);
    cmp("offset", e_offs, offset_code);
    cmp("clear", e_clr, clear_code);
    cmp("control", e_ctl, ctrl_write);
    cmp("read", e_rd, {read_dest, read_channel});
    cmp("pulses", {x_ctl, x_rd, x_dis}, {n_ctl, n_rd, n_dis});
  endtask : check_all

  task automatic reset_exp();
    e_out  = {4{RST_DATA}};
    e_gain = {4{RST_GAIN}};
    e_offs = {4{RST_OFFSET}};
    e_clr  = {4{RST_CLEAR}};
    e_ctl  = '0;
    e_rd   = 5'h00;
  endtask : reset_exp

  // expectation worked out from the frame bits, length and check pin alone
  task automatic frame(input logic [31:0] f, input int n);
    logic [23:0] fr;
    logic [1:0]  c;
    fr = (n == 32) ? f[31:8] : f[23:0];
    c  = fr[17:16];
    host.send(f, n);
    if (n != (packet_error_check ? 32 : 24) || fr[22:21] != A || fr[20:18] == 3'h1) x_dis++;
    else if (fr[23]) begin
      x_rd++;
      e_rd = fr[20:16];
    end else case (fr[20:18])
      3'h0: e_out[c] = fr[15:4];
      3'h2: e_gain[c] = fr[15:4];
      3'h3: e_gain = {4{fr[15:4]}};
      3'h4: e_offs[c] = fr[15:4];
      3'h5: e_offs = {4{fr[15:4]}};
      3'h6: e_clr[c] = fr[15:4];
      default: begin
        x_ctl++;
        e_ctl = {fr[15:13], fr[17:16], fr[12:0]};
      end
    endcase
    repeat (8) @(negedge ref_clk);
    check_all();
  endtask : frame

  initial begin
    #3_000_000;
    errors++;
    stop_test();
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    errors = 0;
    total_checks = 0;
    {n_ctl, n_rd, n_dis, x_ctl, x_rd, x_dis} = '0;
    packet_error_check = 1'b0;
    addr_strap_pin_hi = 1'b1;
    addr_strap_pin_lo = 1'b0;
    reset_n = 1'b0;
    reset_exp();
    repeat (16) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (8) @(negedge ref_clk);
    check_all();
    for (int i = 0; i < 4; i++) frame({1'b0, A, 3'h0, i[1:0], i[3:0], 8'hc5, 4'ha}, 24);
    for (int k = 0; k < 10; k++) frame(tbl[k], 24);
    frame({1'b0, A, 3'h0, 2'h1, 16'h6661}, 23);
    frame({1'b0, A, 3'h0, 2'h1, 16'h6661, 1'b0}, 25);
    packet_error_check = 1'b1;
    frame({1'b0, A, 3'h0, 2'h2, 16'hbcd7, 8'h5e}, 32);
    frame({1'b0, A, 3'h6, 2'h2, 16'h1110}, 24);
    packet_error_check = 1'b0;
    reset_n = 1'b0;
    reset_exp();
    repeat (3) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (8) @(negedge ref_clk);
    check_all();
    frame({1'b0, A, 3'h0, 2'h3, 16'hfff0}, 24);
    stop_test();
  end
endmodule : dwf_frame_decoder_bench
`default_nettype wire
